/* File: verification/anx_props.sv */
// Checker of read answers and status bit behaviour at the bank's ports
`timescale 1ns/1ps
module anx_props
  import anx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lcw_valid,
  input wire logic [15:0] lcw_data,
  input wire logic par_fault_evt,
  input wire logic flp_valid,
  input wire logic rd_stb,
  input wire logic [4:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic sel_supported
);
  wire r5 = rd_stb && rd_addr == ANX_OFS_PARTNER;
  wire r6 = rd_stb && rd_addr == ANX_OFS_EXPANSION;
  wire ev = lcw_valid || par_fault_evt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_part_rsvd: assert property (r5 |=> rd_valid && rd_data[12:9] == 4'h0) else $error("partner zero bits");
  chk_exp_rsvd: assert property (r6 |=> rd_valid && rd_data[15:5] == 11'h000 && rd_data[2])
    else $error("expansion fixed bits");
  chk_lcw_load: assert property (lcw_valid ##1 r5 |=> rd_data == ($past(lcw_data, 2) & 16'hE1FF))
    else $error("partner word not stored");
  chk_page_set: assert property (lcw_valid ##1 r6 |=> rd_data[1] && rd_data[3] == $past(lcw_data[15], 2))
    else $error("page flags wrong");
  chk_read_clear: assert property ((r6 && !ev) ##1 r6 |=> !rd_data[4] && !rd_data[1]) else $error("no clear");
  chk_fault_latch: assert property (par_fault_evt ##1 r6 |=> rd_data[4]) else $error("fault not latched");
  chk_an_able: assert property (flp_valid ##1 r6 |=> rd_data[0]) else $error("partner able not set");
  chk_sel_flag: assert property (lcw_valid |=> sel_supported == ($past(lcw_data[4:0]) == ANX_SEL_IEEE8023))
    else $error("selector flag wrong");
  cover property (lcw_valid ##1 r5);
  cover property (r6 ##1 r6);
  cover property (par_fault_evt ##1 r6);
endmodule : anx_props
bind anx_partner_regs anx_props chk_u (.clk(clk), .rst_n(rst_n), .lcw_valid(lcw_valid), .lcw_data(lcw_data),
  .par_fault_evt(par_fault_evt), .flp_valid(flp_valid), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data),
  .rd_valid(rd_valid), .sel_supported(sel_supported));

/* File: verification/anx_sta_model.sv */
// Station manager model that issues register reads
`timescale 1ns/1ps
module anx_sta_model (
  input wire logic clk,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  output logic rd_stb,
  output logic [4:0] rd_addr
);
  initial rd_stb = 1'b0;
  initial rd_addr = 5'h1F;
  // Reads only, so reserved bits are never written
  task rd(input logic [4:0] a, input int n, output logic [16:0] d);
    @(negedge clk);
    rd_stb = 1'b1;
    rd_addr = a;
    repeat (n) @(negedge clk);
    rd_stb = 1'b0;
    // Released address flips so a stale value is never read as held
    rd_addr = ~a;
    d = {rd_valid, rd_data};
  endtask : rd
endmodule : anx_sta_model

/* File: verification/testbench.sv */
// Self-checking bench for the partner ability and expansion registers
`timescale 1ns/1ps
module testbench;
  import anx_pkg::*;
  logic clk, rst_n, lcw_valid, par_fault_evt, flp_valid, rd_stb, rd_valid, sel_supported, pf, an;
  logic [15:0] lcw_data, rd_data, w;
  logic [4:0] rd_addr;
  logic [16:0] d;
  int err_total, samples_checked, cyc;
  anx_partner_regs dut_u (.clk(clk), .rst_n(rst_n), .lcw_valid(lcw_valid), .lcw_data(lcw_data),
    .par_fault_evt(par_fault_evt), .flp_valid(flp_valid), .rd_stb(rd_stb), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .sel_supported(sel_supported));
  anx_sta_model sta_u (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .rd_stb(rd_stb), .rd_addr(rd_addr));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [16:0] exp_x(logic f, logic np, logic pg, logic a);
    return {12'h800, f, np, 1'b1, pg, a};
  endfunction : exp_x
  task chk(input logic [16:0] g, input logic [16:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task wrap_up;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    {rst_n, lcw_valid, par_fault_evt, flp_valid, an} = 5'h00;
    lcw_data = 16'h0000;
    void'($urandom(32'h82f4));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    sta_u.rd(ANX_OFS_PARTNER, 1, d);
    chk(d, 17'h1_0000);
    sta_u.rd(ANX_OFS_EXPANSION, 1, d);
    chk(d, 17'h1_0004);
    for (int i = 0; i < 40; i++)
    begin
      w = 16'($urandom);
      // First two words carry the supported and the other defined selector
      if (i < 2)
        w[4:0] = i ? ANX_SEL_IEEE8029 : ANX_SEL_IEEE8023;
      pf = 1'($urandom);
      @(negedge clk);
      lcw_valid = 1'b1;
      lcw_data = w;
      par_fault_evt = pf;
      flp_valid = 1'($urandom);
      an = an | flp_valid;
      @(negedge clk);
      lcw_valid = 1'b0;
      par_fault_evt = 1'b0;
      lcw_data = ~w;
      chk({16'h0000, sel_supported}, {16'h0000, w[4:0] == ANX_SEL_IEEE8023});
      // Partner contents are trusted only once a received code word has been stored
      sta_u.rd(ANX_OFS_PARTNER, 1, d);
      chk(d, {1'b1, w & 16'hE1FF});
      sta_u.rd(ANX_OFS_EXPANSION, 1, d);
      chk(d, exp_x(pf, w[15], 1'b1, an));
      sta_u.rd(ANX_OFS_EXPANSION, 2, d);
      chk(d, exp_x(1'b0, w[15], 1'b0, an));
      sta_u.rd(5'(7 + $urandom % 25), 1, d);
      chk(d, 17'h1_0000);
    end
    // Fault event in the same cycle as an expansion read: the set must win over the clear
    fork
      sta_u.rd(ANX_OFS_EXPANSION, 1, d);
      begin
        @(negedge clk);
        par_fault_evt = 1'b1;
        @(negedge clk);
        par_fault_evt = 1'b0;
      end
    join
    chk(d, exp_x(1'b0, w[15], 1'b0, an));
    sta_u.rd(ANX_OFS_EXPANSION, 1, d);
    chk(d, exp_x(1'b1, w[15], 1'b0, an));
    // Reset in mid-run drops every learned status back to its reset value
    @(negedge clk);
    rst_n = 1'b0;
    flp_valid = 1'b0;
    lcw_data = 16'h0000;
    repeat (2) @(negedge clk);
    chk({rd_valid, rd_data}, 17'h0_0000);
    chk({16'h0000, sel_supported}, 17'h0_0000);
    rst_n = 1'b1;
    an = 1'b0;
    sta_u.rd(ANX_OFS_PARTNER, 1, d);
    chk(d, 17'h1_0000);
    sta_u.rd(ANX_OFS_EXPANSION, 1, d);
    chk(d, exp_x(1'b0, 1'b0, 1'b0, 1'b0));
    wrap_up();
  end
endmodule : testbench

/* File: verilog/anx_partner_regs.sv */
`timescale 1ns/1ps
// Partner ability and auto-negotiation expansion status registers
// Summary of operation
// - Partner ability register loads from each received link code word
// - Bit 15 shows partner next page flag
// - Bit 14 shows partner acknowledge of local code word
// - Bit 13 shows partner remote fault flag
// - Technology field bits 8..5 come from received code word
// - Reserved partner bits 12..10 always read zero
// - Bit 9 (T4 ability) always reads zero
// - Bits 8..5 report partner TX full, TX half, T full, T half
// - Selector field bits 4..0 hold partner encoding code
// - Expansion bits 15..5 always read zero
// - Expansion bit 3 shows partner next page ability
// - Expansion bit 2 reads one, local next page able
// - Expansion bit 1 shows new page received
// - Parallel detection fault latches high until expansion read
// - Page received sets on store, clears on expansion read
// - Expansion bit 0 sets once valid pulse bursts arrive
module anx_partner_regs
  import anx_pkg::*;
#(
  parameter int DATA_W = ANX_DATA_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lcw_valid,
  input wire logic [anx_pkg::ANX_DATA_W-1:0] lcw_data,
  input wire logic par_fault_evt,
  input wire logic flp_valid,
  input wire logic rd_stb,
  input wire logic [anx_pkg::ANX_ADDR_W-1:0] rd_addr,
  output logic [anx_pkg::ANX_DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic sel_supported
);
  import anx_pkg::*;

  logic [DATA_W-1:0] partner_ff;
  logic [DATA_W-1:0] nxt_partner;
  logic par_fault_ff;
  logic nxt_par_fault;
  logic lp_np_able_ff;
  logic nxt_lp_np_able;
  logic page_rx_ff;
  logic nxt_page_rx;
  logic lp_an_able_ff;
  logic nxt_lp_an_able;
  logic [DATA_W-1:0] rd_data_ff;
  logic [DATA_W-1:0] nxt_rd_data;
  logic rd_valid_ff;
  logic nxt_rd_valid;
  logic sel_ok_ff;
  logic nxt_sel_ok;
  logic [DATA_W-1:0] expansion;
  logic [DATA_W-1:0] masked_lcw;

  anx_read_if rif ();

  assign rif.rd_stb = rd_stb;
  assign rif.rd_addr = rd_addr;
  assign rif.partner = partner_ff;
  assign rif.expansion = expansion;

  anx_read_mux u_mux (
    .rif(rif)
  );

  always_comb
  begin
    masked_lcw = lcw_data;
    masked_lcw[ANX_PA_RSVD_HI:ANX_PA_RSVD_LO] = '0;
    masked_lcw[ANX_PA_T4] = 1'b0;
  end

  // Partner word group: the stored code word and what is derived from it
  always_comb
  begin
    nxt_partner = partner_ff;
    nxt_lp_np_able = lp_np_able_ff;
    nxt_sel_ok = sel_ok_ff;
    if (lcw_valid)
    begin
      nxt_partner = masked_lcw;
      nxt_lp_np_able = lcw_data[ANX_PA_NEXT_PAGE];
      nxt_sel_ok = (lcw_data[ANX_PA_SEL_HI:ANX_PA_SEL_LO] == ANX_SEL_IEEE8023);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      partner_ff <= ANX_PARTNER_RST;
      lp_np_able_ff <= 1'b0;
      sel_ok_ff <= 1'b0;
    end
    else
    begin
      partner_ff <= nxt_partner;
      lp_np_able_ff <= nxt_lp_np_able;
      sel_ok_ff <= nxt_sel_ok;
    end
  end

  // Status flag group. Fault and page received flags clear on an expansion read, but a new event in
  // the read cycle wins, so an event is never lost between two polls
  always_comb
  begin
    nxt_par_fault = par_fault_ff;
    if (rif.rd_expansion)
    begin
      nxt_par_fault = 1'b0;
    end
    if (par_fault_evt)
    begin
      nxt_par_fault = 1'b1;
    end
    nxt_page_rx = page_rx_ff;
    if (rif.rd_expansion)
    begin
      nxt_page_rx = 1'b0;
    end
    if (lcw_valid)
    begin
      nxt_page_rx = 1'b1;
    end
    // Sticky: only a reset forgets a partner that was once seen negotiating
    nxt_lp_an_able = lp_an_able_ff | flp_valid;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      par_fault_ff <= 1'b0;
      page_rx_ff <= 1'b0;
      lp_an_able_ff <= 1'b0;
    end
    else
    begin
      par_fault_ff <= nxt_par_fault;
      page_rx_ff <= nxt_page_rx;
      lp_an_able_ff <= nxt_lp_an_able;
    end
  end

  // Read answer group: data and valid stand for one cycle after the request
  always_comb
  begin
    nxt_rd_data = rif.rd_data;
    nxt_rd_valid = rd_stb;
  end

  always_comb
  begin
    expansion = '0;
    expansion[ANX_EX_PAR_FAULT] = par_fault_ff;
    expansion[ANX_EX_LP_NP_ABLE] = lp_np_able_ff;
    expansion[ANX_EX_NP_ABLE] = ANX_LOCAL_NP_ABLE;
    expansion[ANX_EX_PAGE_RX] = page_rx_ff;
    expansion[ANX_EX_LP_AN_ABLE] = lp_an_able_ff;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_ff <= '0;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign sel_supported = sel_ok_ff;
endmodule : anx_partner_regs

/* File: verilog/anx_pkg.sv */
// Package of offsets, field positions and reset values for the partner ability and expansion registers
package anx_pkg;
  localparam int ANX_DATA_W = 16;
  localparam int ANX_ADDR_W = 5;
  localparam logic [4:0] ANX_OFS_PARTNER = 5'h05;
  localparam logic [4:0] ANX_OFS_EXPANSION = 5'h06;
  // Partner ability field positions
  localparam int ANX_PA_NEXT_PAGE = 15;
  localparam int ANX_PA_ACK = 14;
  localparam int ANX_PA_REMOTE_FAULT = 13;
  localparam int ANX_PA_RSVD_HI = 12;
  localparam int ANX_PA_RSVD_LO = 10;
  localparam int ANX_PA_T4 = 9;
  localparam int ANX_PA_TX_FD = 8;
  localparam int ANX_PA_TX_HD = 7;
  localparam int ANX_PA_T_FD = 6;
  localparam int ANX_PA_T_HD = 5;
  localparam int ANX_PA_SEL_HI = 4;
  localparam int ANX_PA_SEL_LO = 0;
  localparam logic [4:0] ANX_SEL_IEEE8023 = 5'h01;
  localparam logic [4:0] ANX_SEL_IEEE8029 = 5'h02;
  // Expansion field positions
  localparam int ANX_EX_PAR_FAULT = 4;
  localparam int ANX_EX_LP_NP_ABLE = 3;
  localparam int ANX_EX_NP_ABLE = 2;
  localparam int ANX_EX_PAGE_RX = 1;
  localparam int ANX_EX_LP_AN_ABLE = 0;
  // Reset values
  localparam logic [15:0] ANX_PARTNER_RST = 16'h0000;
  localparam logic [15:0] ANX_EXPANSION_RST = 16'h0004;
  localparam logic ANX_LOCAL_NP_ABLE = 1'b1;
endpackage : anx_pkg

/* File: verilog/anx_read_if.sv */
`timescale 1ns/1ps
// Interface carrying a register read request and its data between the bank and its read mux
interface anx_read_if;
  logic rd_stb;
  logic [4:0] rd_addr;
  logic [15:0] partner;
  logic [15:0] expansion;
  logic [15:0] rd_data;
  logic rd_partner;
  logic rd_expansion;
  modport bank (output rd_stb, output rd_addr, output partner, output expansion, input rd_data,
    input rd_partner, input rd_expansion);
  modport mux (input rd_stb, input rd_addr, input partner, input expansion, output rd_data,
    output rd_partner, output rd_expansion);
endinterface : anx_read_if

/* File: verilog/anx_read_mux.sv */
`timescale 1ns/1ps
// Read decode: selects register contents by address and flags which register was read
module anx_read_mux
  import anx_pkg::*;
(
  anx_read_if.mux rif
);
  always_comb
  begin
    rif.rd_data = '0;
    rif.rd_partner = 1'b0;
    rif.rd_expansion = 1'b0;
    if (rif.rd_stb)
    begin
      case (rif.rd_addr)
        ANX_OFS_PARTNER:
        begin
          rif.rd_data = rif.partner;
          rif.rd_partner = 1'b1;
        end
        ANX_OFS_EXPANSION:
        begin
          rif.rd_data = rif.expansion;
          rif.rd_expansion = 1'b1;
        end
        // Other addresses belong to other banks and read as zero here
        default:
        begin
          rif.rd_data = '0;
        end
      endcase
    end
  end
endmodule : anx_read_mux
